// ==== inc/rtct_pkg.sv ====
// Shared constants of the real-time-clock timer and interrupt block.
package rtct_pkg;

    // Register byte offsets on the slave port.
    localparam logic [6:0] OFF_IEN   = 7'h1c;
    localparam logic [6:0] OFF_RAW   = 7'h20;
    localparam logic [6:0] OFF_MSK   = 7'h24;
    localparam logic [6:0] OFF_CLR   = 7'h28;
    localparam logic [6:0] OFF_TDR   = 7'h2c;
    localparam logic [6:0] OFF_TCR   = 7'h30;
    localparam logic [6:0] OFF_LD1   = 7'h34;
    localparam logic [6:0] OFF_LD2   = 7'h38;
    localparam logic [6:0] OFF_PAT0  = 7'h3c;
    localparam logic [6:0] OFF_TIN   = 7'h4c;
    localparam logic [6:0] OFF_TRIM  = 7'h50;
    localparam logic [6:0] WORD_STEP = 7'h04;

    // Interrupt bit positions, shared by enable, status and clear words.
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_CD    = 1;

    // Timer control field positions.
    localparam int TCR_OS     = 0;
    localparam int TCR_EN     = 1;
    localparam int TCR_SS     = 2;
    localparam int TCR_LEN_LO = 4;
    localparam int TCR_LEN_HI = 10;
    localparam int TCR_CLK    = 11;
    localparam int TCR_BYP    = 12;

    // Widths and reset values.
    localparam int          PAT_WORDS   = 4;
    localparam int          PAT_BITS    = 128;
    localparam int          LEN_W       = 7;
    localparam int          TRIM_W      = 10;
    localparam int          DIV_W       = 12;
    localparam logic [31:0] TDR_RESET   = 32'hffff_ffff;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

    // Slow reference rate, derived from the system clock by a divider.
    localparam int              CLK_HZ      = 125_000_000;
    localparam int              SLOW_HZ     = 32_768;
    localparam logic [DIV_W-1:0] SLOW_DIV   = DIV_W'(CLK_HZ / SLOW_HZ);
    localparam logic [TRIM_W-1:0] TRIM_WIN  = 10'h3ff;

endpackage : rtct_pkg

// ==== hw/rtct_tick.sv ====
// Slow reference tick divider with trim pulse deletion.
`timescale 1ns/1ps
module rtct_tick (
    input  wire logic                          clk_sys,   // System clock.
    input  wire logic                          arst_n,    // Asynchronous reset, active low.
    input  wire logic                          run,       // Divider runs while high.
    input  wire logic [rtct_pkg::TRIM_W-1:0]   trim_cnt,  // Ticks deleted per window.
    output logic                               raw_tick,  // Untrimmed slow tick pulse.
    output logic                               trim_tick  // Trimmed slow tick pulse.
);

    typedef struct packed {
        logic [rtct_pkg::DIV_W-1:0]  div;
        logic [rtct_pkg::TRIM_W-1:0] win;
        logic                        raw;
        logic                        trim;
    } rtct_tick_t;

    rtct_tick_t s_r;
    rtct_tick_t s_nxt;

    // Deleted ticks sit at the start of each window, so the loss is bunched, not spread.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.raw  = 1'b0;
        s_nxt.trim = 1'b0;
        if (!run) begin
            s_nxt.div = '0;
        end else if (s_r.div == rtct_pkg::SLOW_DIV - 1'b1) begin
            s_nxt.div  = '0;
            s_nxt.raw  = 1'b1;
            s_nxt.trim = (s_r.win >= trim_cnt);
            s_nxt.win  = (s_r.win == rtct_pkg::TRIM_WIN - 1'b1) ? '0 : s_r.win + 1'b1;
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign raw_tick  = s_r.raw;
    assign trim_tick = s_r.trim;

endmodule : rtct_tick

// ==== hw/rtct_count.sv ====
// Down counter with pattern-driven choice of reload value.
`timescale 1ns/1ps
module rtct_count (
    input  wire logic                           clk_sys,   // System clock.
    input  wire logic                           arst_n,    // Asynchronous reset, active low.
    input  wire logic                           tick,      // Selected slow tick.
    input  wire logic                           run,       // Timer enable.
    input  wire logic                           one_shot,  // Stop at zero when high.
    input  wire logic                           load_stb,  // Direct load while stopped.
    input  wire logic [31:0]                    load_val,  // Value for direct load.
    input  wire logic [31:0]                    ld1,       // First reload value.
    input  wire logic [31:0]                    ld2,       // Second reload value.
    input  wire logic [rtct_pkg::PAT_BITS-1:0]  pattern,   // Reload choice pattern.
    input  wire logic [rtct_pkg::LEN_W-1:0]     pat_len,   // Useful pattern length.
    output logic [31:0]                         cnt,       // Current count.
    output logic                                zero_pls   // One-cycle zero event.
);

    typedef struct packed {
        logic [31:0]                cnt;
        logic [rtct_pkg::LEN_W-1:0] ptr;
        logic                       zp;
    } rtct_cnt_t;

    localparam rtct_cnt_t CNT_RST = '{cnt: rtct_pkg::TDR_RESET, default: '0};

    rtct_cnt_t s_r;
    rtct_cnt_t s_nxt;

    // Count, reload and pointer stepping; nothing but a direct load moves without run and tick.
    always_comb begin
        s_nxt    = s_r;
        s_nxt.zp = 1'b0;
        if (load_stb) begin
            s_nxt.cnt = load_val;
            s_nxt.ptr = '0;
        end else if (tick && run) begin
            if (s_r.cnt <= 32'h0000_0001) begin
                s_nxt.zp = 1'b1;
                if (one_shot) begin
                    s_nxt.cnt = rtct_pkg::WORD_ZERO;
                end else begin
                    s_nxt.cnt = pattern[s_r.ptr] ? ld2 : ld1;
                    s_nxt.ptr = (s_r.ptr + 1'b1 >= pat_len) ? '0 : s_r.ptr + 1'b1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= CNT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cnt      = s_r.cnt;
    assign zero_pls = s_r.zp;

endmodule : rtct_count

// ==== hw/rtct_top.sv ====
// Timer and interrupt logic of the real-time clock, with an Avalon-MM slave port.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// - Alarm enable bit 0 resets to 0 and gates the alarm interrupt.
// - Countdown enable bit 1 resets to 0 and gates the countdown interrupt.
// - Raw status bit 0 shows the alarm event, ignoring enables.
// - Raw status bit 1 shows the countdown event, ignoring enables.
// - Masked status is raw AND enable per bit; these drive the outputs.
// - Writing 1 to clear bit 0 drops the alarm event; 0 does nothing.
// - Writing 1 to clear bit 1 drops the countdown event; 0 does nothing.
// - Periodic mode: event at zero, reload from chosen value, keep counting.
// - One-shot mode: event at zero, then counting stops.
// - Enable bit starts or stops counting on the next slow tick.
// - A stopped counter holds its value.
// - Writing a reload register while stopped sets the enable bit.
// - In one-shot mode the enable bit clears itself at zero.
// - With self-start set, reload or pattern writes set the enable bit.
// - Length field bits 10:4 sets how many pattern bits are stepped.
// - Clock select bit 11: 0 untrimmed tick, 1 trimmed tick.
// - Gating override bit 12 keeps the tick divider always running.
// - Two 32-bit reload registers, reset to zero, supply reloads.
// - 128-bit pattern in four words, lowest word holds bits 31:0.
// - Trimmed tick drops a programmed number of ticks per 1023.
// - Read-only 32-bit register counts countdown events.
module rtct_top (
    input  wire logic        clk_sys,          // System clock, 125 MHz.
    input  wire logic        arst_n,           // Asynchronous reset, active low.
    input  wire logic [6:0]  avs_address,      // Byte address of the register.
    input  wire logic        avs_read,         // Read request.
    input  wire logic        avs_write,        // Write request.
    input  wire logic [31:0] avs_writedata,    // Write data.
    input  wire logic [3:0]  avs_byteenable,   // Write byte lanes.
    output logic [31:0]      avs_readdata,     // Read data.
    output logic             avs_waitrequest,  // Stall, high while not answering.
    input  wire logic        alarm_event,      // One-cycle clockwatch match pulse.
    output logic             alarm_irq_out,    // Masked alarm interrupt.
    output logic             countdown_irq_out // Masked countdown interrupt.
);

    typedef struct packed {
        logic [1:0]                        ien;
        logic [1:0]                        raw;
        logic                              irq_a;
        logic                              irq_c;
        logic                              os;
        logic                              en;
        logic                              ss;
        logic [rtct_pkg::LEN_W-1:0]        len;
        logic                              clksel;
        logic                              byp;
        logic [31:0]                       ld1;
        logic [31:0]                       ld2;
        logic [rtct_pkg::PAT_BITS-1:0]     pat;
        logic [31:0]                       countdown_event_count;
        logic [rtct_pkg::TRIM_W-1:0]       trim;
        logic                              wait_r;
        logic [31:0]                       rdata;
    } rtct_state_t;

    localparam rtct_state_t TOP_RST = '{wait_r: 1'b1, default: '0};

    rtct_state_t s_r;
    rtct_state_t s_nxt;

    logic        req;
    logic        commit;
    logic        wr;
    logic        ld_wr;
    logic        pat_wr;
    logic        load_stb;
    logic [31:0] rd_word;
    logic [31:0] mrg;
    logic [1:0]  clr_bits;
    logic        raw_tick;
    logic        trim_tick;
    logic        tick;
    logic [31:0] cnt;
    logic        zp;

    // Merges write data into the present word lane by lane.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Packs the timer control fields; unused positions stay zero.
    function automatic logic [31:0] tcr_word(input rtct_state_t st);
        logic [31:0] w;
        w = rtct_pkg::WORD_ZERO;
        w[rtct_pkg::TCR_OS] = st.os;
        w[rtct_pkg::TCR_EN] = st.en;
        w[rtct_pkg::TCR_SS] = st.ss;
        w[rtct_pkg::TCR_LEN_HI:rtct_pkg::TCR_LEN_LO] = st.len;
        w[rtct_pkg::TCR_CLK] = st.clksel;
        w[rtct_pkg::TCR_BYP] = st.byp;
        return w;
    endfunction : tcr_word

    // Bus handshake: the slave answers on the second edge of every request.
    assign req    = avs_read | avs_write;
    assign commit = req & ~s_r.wait_r;
    assign wr     = avs_write & commit;

    // Register read view; unmapped and write-only words read zero.
    always_comb begin
        rd_word = rtct_pkg::WORD_ZERO;
        case (avs_address)
            rtct_pkg::OFF_IEN:  rd_word[1:0] = s_r.ien;
            rtct_pkg::OFF_RAW:  rd_word[1:0] = s_r.raw;
            rtct_pkg::OFF_MSK:  rd_word[1:0] = s_r.raw & s_r.ien;
            rtct_pkg::OFF_TDR:  rd_word = cnt;
            rtct_pkg::OFF_TCR:  rd_word = tcr_word(s_r);
            rtct_pkg::OFF_LD1:  rd_word = s_r.ld1;
            rtct_pkg::OFF_LD2:  rd_word = s_r.ld2;
            rtct_pkg::OFF_TIN:  rd_word = s_r.countdown_event_count;
            rtct_pkg::OFF_TRIM: rd_word[rtct_pkg::TRIM_W-1:0] = s_r.trim;
            default: begin
                for (int i = 0; i < rtct_pkg::PAT_WORDS; i++) begin
                    if (avs_address == rtct_pkg::OFF_PAT0 + 7'(i * 4)) begin
                        rd_word = s_r.pat[32*i +: 32];
                    end
                end
            end
        endcase
    end

    // Write word; reading the view first keeps reserved bits at zero after a partial write.
    assign mrg      = be_merge(rd_word, avs_writedata, avs_byteenable);
    assign ld_wr    = wr & ((avs_address == rtct_pkg::OFF_LD1) | (avs_address == rtct_pkg::OFF_LD2));
    assign pat_wr   = wr & (avs_address >= rtct_pkg::OFF_PAT0)
                         & (avs_address < rtct_pkg::OFF_PAT0 + 7'(rtct_pkg::PAT_WORDS * 4));
    assign load_stb = ld_wr & ~s_r.en;
    assign clr_bits = (wr && avs_address == rtct_pkg::OFF_CLR) ? mrg[1:0] : 2'h0;

    // Tick source: divider gated off while stopped unless the override holds it running.
    rtct_tick u_tick (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .run       (s_r.en | s_r.byp),
        .trim_cnt  (s_r.trim),
        .raw_tick  (raw_tick),
        .trim_tick (trim_tick)
    );

    assign tick = s_r.clksel ? trim_tick : raw_tick;

    // Counter core.
    rtct_count u_count (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick     (tick),
        .run      (s_r.en),
        .one_shot (s_r.os),
        .load_stb (load_stb),
        .load_val (mrg),
        .ld1      (s_r.ld1),
        .ld2      (s_r.ld2),
        .pattern  (s_r.pat),
        .pat_len  (s_r.len),
        .cnt      (cnt),
        .zero_pls (zp)
    );

    // Next state of registers, flags and bus answer.
    always_comb begin
        s_nxt        = s_r;
        s_nxt.wait_r = ~(req & s_r.wait_r);
        if (avs_read && s_r.wait_r) begin
            s_nxt.rdata = rd_word;
        end
        if (wr) begin
            case (avs_address)
                rtct_pkg::OFF_IEN: s_nxt.ien = mrg[1:0];
                rtct_pkg::OFF_TCR: begin
                    s_nxt.os     = mrg[rtct_pkg::TCR_OS];
                    s_nxt.en     = mrg[rtct_pkg::TCR_EN];
                    s_nxt.ss     = mrg[rtct_pkg::TCR_SS];
                    s_nxt.len    = mrg[rtct_pkg::TCR_LEN_HI:rtct_pkg::TCR_LEN_LO];
                    s_nxt.clksel = mrg[rtct_pkg::TCR_CLK];
                    s_nxt.byp    = mrg[rtct_pkg::TCR_BYP];
                end
                rtct_pkg::OFF_LD1:  s_nxt.ld1  = mrg;
                rtct_pkg::OFF_LD2:  s_nxt.ld2  = mrg;
                rtct_pkg::OFF_TRIM: s_nxt.trim = mrg[rtct_pkg::TRIM_W-1:0];
                default: begin
                    for (int i = 0; i < rtct_pkg::PAT_WORDS; i++) begin
                        if (avs_address == rtct_pkg::OFF_PAT0 + 7'(i * 4)) begin
                            s_nxt.pat[32*i +: 32] = mrg;
                        end
                    end
                end
            endcase
        end
        // Hardware clears after software writes; hardware sets come last and win.
        if (zp && s_r.os) begin
            s_nxt.en = 1'b0;
        end
        if (load_stb || (s_r.ss && (ld_wr || pat_wr))) begin
            s_nxt.en = 1'b1;
        end
        // A new event in the clearing cycle survives the clear.
        s_nxt.raw[rtct_pkg::IRQ_ALARM] = (s_r.raw[rtct_pkg::IRQ_ALARM] & ~clr_bits[rtct_pkg::IRQ_ALARM])
                                         | alarm_event;
        s_nxt.raw[rtct_pkg::IRQ_CD]    = (s_r.raw[rtct_pkg::IRQ_CD] & ~clr_bits[rtct_pkg::IRQ_CD])
                                         | zp;
        if (zp) begin
            s_nxt.countdown_event_count = s_r.countdown_event_count + 1'b1;
        end
        s_nxt.irq_a = s_nxt.raw[rtct_pkg::IRQ_ALARM] & s_nxt.ien[rtct_pkg::IRQ_ALARM];
        s_nxt.irq_c = s_nxt.raw[rtct_pkg::IRQ_CD] & s_nxt.ien[rtct_pkg::IRQ_CD];
    end

    // State register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata      = s_r.rdata;
    assign avs_waitrequest   = s_r.wait_r;
    assign alarm_irq_out     = s_r.irq_a;
    assign countdown_irq_out = s_r.irq_c;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    alarm_irq_gate_a: assert property (alarm_irq_out == (s_r.raw[0] & s_r.ien[0]))
        else $error("Alarm interrupt does not follow raw and enable.");
    cd_irq_gate_a: assert property (countdown_irq_out == (s_r.raw[1] & s_r.ien[1]))
        else $error("Countdown interrupt does not follow raw and enable.");
    alarm_raw_set_a: assert property (alarm_event |=> s_r.raw[0] && alarm_irq_out == s_r.ien[0])
        else $error("Alarm event not latched.");
    cd_raw_set_a: assert property (zp |=> s_r.raw[1] && s_r.countdown_event_count == $past(s_r.countdown_event_count) + 1'b1)
        else $error("Countdown event not latched or not counted.");
    masked_read_a: assert property (avs_read && !avs_waitrequest && $past(avs_address) == rtct_pkg::OFF_MSK
                                    |-> avs_readdata[1:0] == ($past(s_r.raw) & $past(s_r.ien)))
        else $error("Masked status read wrong.");
    alarm_clear_a: assert property (wr && avs_address == rtct_pkg::OFF_CLR && avs_byteenable[0]
                                    && avs_writedata[0] && !alarm_event |=> !s_r.raw[0])
        else $error("Alarm clear ignored.");
    clear_zero_a: assert property (wr && avs_address == rtct_pkg::OFF_CLR && !avs_writedata[1]
                                   && s_r.raw[1] |=> s_r.raw[1])
        else $error("Writing zero cleared the countdown flag.");
    cd_clear_a: assert property (wr && avs_address == rtct_pkg::OFF_CLR && avs_byteenable[0]
                                 && avs_writedata[1] && !zp |=> !s_r.raw[1])
        else $error("Countdown clear ignored.");
    periodic_run_a: assert property (zp && !s_r.os && !wr |=> s_r.en)
        else $error("Periodic timer stopped at zero.");
    // A load in the zero cycle or a mode change since the tick may rightly move the count, so both are excluded.
    oneshot_stop_a: assert property (zp && s_r.os && $past(s_r.os) && !(s_r.ss && (ld_wr || pat_wr)) && !load_stb
                                     |=> !s_r.en && cnt == rtct_pkg::WORD_ZERO)
        else $error("One-shot timer kept running.");
    stopped_hold_a: assert property (!s_r.en && !load_stb |=> $stable(cnt))
        else $error("Stopped counter changed.");
    load_start_a: assert property (load_stb |=> s_r.en && cnt == $past(mrg))
        else $error("Load while stopped did not start the timer.");
    self_start_a: assert property (pat_wr && s_r.ss |=> s_r.en)
        else $error("Self-start did not enable the timer.");
    tcr_reserved_a: assert property (avs_read && !avs_waitrequest && $past(avs_address) == rtct_pkg::OFF_TCR
                                     |-> (avs_readdata & 32'hffff_e008) == 32'h0000_0000)
        else $error("Reserved control bits read nonzero.");
    bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("Slave did not answer in one cycle.");

    periodic_reload_c: cover property (zp && !s_r.os ##1 s_r.en);
    oneshot_end_c: cover property (zp && s_r.os);
    clear_race_c: cover property (alarm_event && clr_bits[0]);
    trim_tick_c: cover property (raw_tick && !trim_tick && s_r.clksel);

endmodule : rtct_top

// ==== dv/rtct_top_test.sv ====
// Self-checking testbench of the timer and interrupt block.
`timescale 1ns/1ps
module rtct_top_test;
    logic        clk_sys;           // System clock.
    logic        arst_n;            // Reset, active low.
    logic [6:0]  avs_address;       // Bus address.
    logic        avs_read;          // Bus read.
    logic        avs_write;         // Bus write.
    logic [31:0] avs_writedata;     // Bus write data.
    logic [3:0]  avs_byteenable;    // Bus write lanes.
    logic [31:0] avs_readdata;      // Bus read data.
    logic        avs_waitrequest;   // Bus stall.
    logic        alarm_event;       // Alarm match pulse.
    logic        alarm_irq_out;     // Alarm interrupt.
    logic        countdown_irq_out; // Countdown interrupt.
    int          bad_count;
    int          checked;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [31:0] v;

    rtct_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alarm_event(alarm_event),
        .alarm_irq_out(alarm_irq_out), .countdown_irq_out(countdown_irq_out));

    // Free-running 125 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Xorshift source; a fixed seed keeps every run identical.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected word after a write through the given byte lanes.
    function automatic logic [31:0] merge_exp(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (wd & m) | (old & ~m);
    endfunction : merge_exp

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One bus access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rchk(input string nm, input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rchk

    // Polls raw status until the countdown event shows; the bound keeps a dead timer from hanging.
    task automatic wait_cd();
        for (int i = 0; i < 6000; i++) begin
            bus(1'b0, rtct_pkg::OFF_RAW, 32'h0);
            if (rd[1] === 1'b1) break;
        end
        chk("cd event", 32'(rd[1]), 32'h1);
    endtask : wait_cd

    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // Watchdog sized well above the roughly 47000 cycles the tests need.
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    // Main sequence.
    initial begin
        logic [6:0] ra [9];
        ra = '{7'h1c, 7'h20, 7'h24, 7'h28, 7'h2c, 7'h30, 7'h34, 7'h38, 7'h4c};
        {arst_n, avs_read, avs_write, alarm_event} = 4'h0;
        avs_address = 7'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        bad_count = 0;
        checked = 0;
        seed = 32'd26147;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int k = 0; k < 9; k++) rchk("reset", ra[k], ra[k] == 7'h2c ? 32'hffff_ffff : 32'h0);
        rchk("unmapped", 7'h7c, 32'h0);
        $display("test reset done");
        v = rnd();
        bus(1'b1, rtct_pkg::OFF_IEN, v);
        rchk("enable", rtct_pkg::OFF_IEN, v & 32'h3);
        for (int k = 1; k < 4; k++) begin
            v = rnd();
            bus(1'b1, 7'(32'(rtct_pkg::OFF_PAT0) + 4 * k), v);
            rchk("pattern", 7'(32'(rtct_pkg::OFF_PAT0) + 4 * k), v);
        end
        // Partial write: only lanes 0 and 2 of the top pattern word may change.
        avs_byteenable <= 4'h5;
        bus(1'b1, 7'(32'(rtct_pkg::OFF_PAT0) + 12), ~v);
        avs_byteenable <= 4'hf;
        rchk("lanes", 7'(32'(rtct_pkg::OFF_PAT0) + 12), merge_exp(v, ~v, 4'h5));
        v = rnd();
        bus(1'b1, rtct_pkg::OFF_TCR, v);
        rchk("control", rtct_pkg::OFF_TCR, v & 32'h1ff7);
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h0);
        bus(1'b1, rtct_pkg::OFF_IEN, 32'h0);
        bus(1'b1, rtct_pkg::OFF_RAW, 32'hffff_ffff);
        rchk("raw ro", rtct_pkg::OFF_RAW, 32'h0);
        $display("test registers done");
        // Alarm pulse, masking and clearing.
        @(posedge clk_sys);
        alarm_event <= 1'b1;
        @(posedge clk_sys);
        alarm_event <= 1'b0;
        rchk("raw alarm", rtct_pkg::OFF_RAW, 32'h1);
        rchk("masked off", rtct_pkg::OFF_MSK, 32'h0);
        chk("irq off", 32'(alarm_irq_out), 32'h0);
        bus(1'b1, rtct_pkg::OFF_IEN, 32'h1);
        rchk("masked on", rtct_pkg::OFF_MSK, 32'h1);
        chk("irq on", 32'(alarm_irq_out), 32'h1);
        bus(1'b1, rtct_pkg::OFF_CLR, 32'h2);
        rchk("clear zero", rtct_pkg::OFF_RAW, 32'h1);
        bus(1'b1, rtct_pkg::OFF_CLR, 32'h1);
        rchk("clear one", rtct_pkg::OFF_RAW, 32'h0);
        chk("irq cleared", 32'(alarm_irq_out), 32'h0);
        $display("test alarm done");
        // One-shot run from a load written while stopped.
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h1);
        bus(1'b1, rtct_pkg::OFF_LD1, 32'h2);
        rchk("auto enable", rtct_pkg::OFF_TCR, 32'h3);
        wait_cd();
        rchk("os enable", rtct_pkg::OFF_TCR, 32'h1);
        rchk("os count", rtct_pkg::OFF_TDR, 32'h0);
        rchk("events", rtct_pkg::OFF_TIN, 32'h1);
        bus(1'b1, rtct_pkg::OFF_IEN, 32'h2);
        rchk("masked cd", rtct_pkg::OFF_MSK, 32'h2);
        chk("cd irq", 32'(countdown_irq_out), 32'h1);
        bus(1'b1, rtct_pkg::OFF_CLR, 32'h2);
        repeat (8000) @(posedge clk_sys);
        rchk("os hold", rtct_pkg::OFF_TDR, 32'h0);
        rchk("cd cleared", rtct_pkg::OFF_RAW, 32'h0);
        $display("test one-shot done");
        // Periodic run, pattern 2'b10 over length 2 picks first then second reload.
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h20);
        bus(1'b1, rtct_pkg::OFF_PAT0, 32'h2);
        bus(1'b1, rtct_pkg::OFF_LD2, 32'h2);
        bus(1'b1, rtct_pkg::OFF_LD1, 32'h1);
        wait_cd();
        rchk("reload first", rtct_pkg::OFF_TDR, 32'h1);
        bus(1'b1, rtct_pkg::OFF_CLR, 32'h2);
        wait_cd();
        rchk("reload second", rtct_pkg::OFF_TDR, 32'h2);
        rchk("still on", rtct_pkg::OFF_TCR, 32'h22);
        rchk("events", rtct_pkg::OFF_TIN, 32'h3);
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h0);
        repeat (4000) @(posedge clk_sys);
        bus(1'b0, rtct_pkg::OFF_TDR, 32'h0);
        v = rd;
        repeat (8000) @(posedge clk_sys);
        rchk("stopped hold", rtct_pkg::OFF_TDR, v);
        $display("test periodic done");
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h4);
        bus(1'b1, 7'h40, rnd());
        rchk("self start", rtct_pkg::OFF_TCR, 32'h6);
        $display("test self-start done");
        // Deleting every trimmed tick freezes a timer that runs on the trimmed clock.
        bus(1'b1, rtct_pkg::OFF_TRIM, 32'hffff_ffff);
        rchk("trim", rtct_pkg::OFF_TRIM, 32'h3ff);
        bus(1'b1, rtct_pkg::OFF_TCR, 32'h802);
        bus(1'b0, rtct_pkg::OFF_TDR, 32'h0);
        v = rd;
        repeat (8000) @(posedge clk_sys);
        rchk("trim hold", rtct_pkg::OFF_TDR, v);
        $display("test trim done");
        summarize();
    end
endmodule : rtct_top_test
